// [logic/bth_cfg_regs.sv]
// bridge type 1 header slice: bus numbers, fixed fields and I/O base register
`default_nettype none

module bth_cfg_regs
  import bth_pkg::*;
#(
  parameter int AW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output var  logic [31:0]   reg_rdata,
  input  wire logic          cap_lock,
  input  wire logic [3:0]    io_limit_field,
  input  wire logic [15:0]   io_base_upper,
  input  wire logic [15:0]   io_limit_upper,
  input  wire logic          io_req_valid,
  input  wire logic [AW-1:0] io_req_addr,
  output var  logic          io_fwd_valid,
  output var  logic          io_fwd_hit,
  output var  logic          io_cap_mirror,
  output var  logic [3:0]    io_base_field,
  output var  logic [7:0]    downstream_bus_number,
  output var  logic [7:0]    highest_bus_behind
);

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  logic wr_up;
  logic wr_down;
  logic wr_high;
  logic wr_io;

  // one decoded strobe per writable byte; read-only offsets take no strobe
  always_comb begin
    wr_up   = reg_wr && (reg_addr == BTH_OFF_UP_BUS);
    wr_down = reg_wr && (reg_addr == BTH_OFF_DOWN_BUS);
    wr_high = reg_wr && (reg_addr == BTH_OFF_HIGH_BUS);
    wr_io   = reg_wr && (reg_addr == BTH_OFF_IO_LOWER);
  end

  // ---------------------------------------------------------------
  // bus number registers
  // ---------------------------------------------------------------
  logic [7:0] up_bus_d;
  logic [7:0] up_bus_q;
  logic [7:0] down_bus_d;
  logic [7:0] down_bus_q;
  logic [7:0] high_bus_d;
  logic [7:0] high_bus_q;

  // upstream number is stored only for software; nothing inside reads it
  always_comb begin
    up_bus_d   = up_bus_q;
    down_bus_d = down_bus_q;
    high_bus_d = high_bus_q;
    // R5 upstream number store
    if (wr_up) begin
      up_bus_d = reg_wdata[7:0];
    end
    // R6 downstream number store
    if (wr_down) begin
      down_bus_d = reg_wdata[7:0];
    end
    // R7 highest bus store
    if (wr_high) begin
      high_bus_d = reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      up_bus_q   <= BTH_BUS_RST;
      down_bus_q <= BTH_BUS_RST;
      high_bus_q <= BTH_BUS_RST;
    end else begin
      up_bus_q   <= up_bus_d;
      down_bus_q <= down_bus_d;
      high_bus_q <= high_bus_d;
    end
  end

  assign downstream_bus_number = down_bus_q;
  assign highest_bus_behind    = high_bus_q;

  // ---------------------------------------------------------------
  // io_window_lower register
  // ---------------------------------------------------------------
  logic       io_cap;
  logic [3:0] io_base_d;
  logic [3:0] io_base_q;

  // R9 lockable width bit
  bth_lock_bit #(
    .RST_VAL (BTH_IO_CAP_RST)
  ) u_io_cap (
    .clk   (clk),
    .rst   (rst),
    .wr_en (wr_io),
    .lock  (cap_lock),
    .wdata (reg_wdata[BTH_IO_CAP_BIT]),
    .q     (io_cap)
  );

  // R10 window base field
  // R14 bits 3:1 are simply never stored
  always_comb begin
    io_base_d = io_base_q;
    if (wr_io) begin
      io_base_d = reg_wdata[BTH_IO_BASE_MSB:BTH_IO_BASE_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      io_base_q <= BTH_IO_BASE_RST;
    end else begin
      io_base_q <= io_base_d;
    end
  end

  // R13 limit copy of width
  assign io_cap_mirror = io_cap;
  assign io_base_field = io_base_q;

  // ---------------------------------------------------------------
  // forwarding decode
  // ---------------------------------------------------------------
  // R11 window decides forwarding
  bth_io_decode #(
    .AW (AW)
  ) u_io_decode (
    .clk            (clk),
    .rst            (rst),
    .io_cap         (io_cap),
    .io_base_field  (io_base_q),
    .io_limit_field (io_limit_field),
    .io_base_upper  (io_base_upper),
    .io_limit_upper (io_limit_upper),
    .io_req_valid   (io_req_valid),
    .io_req_addr    (io_req_addr),
    .io_fwd_valid   (io_fwd_valid),
    .io_fwd_hit     (io_fwd_hit)
  );

  // ---------------------------------------------------------------
  // read data path
  // ---------------------------------------------------------------
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  // data stand only in the cycle after the strobe, zero otherwise,
  // so a stale value can never be mistaken for a fresh answer
  always_comb begin
    rdata_d = BTH_UNMAPPED_VAL;
    if (reg_rd) begin
      unique case (reg_addr)
        // R1 primary latency zero
        BTH_OFF_PRI_LAT:   rdata_d = {24'h00_0000, BTH_PRI_LAT_VAL};
        // R2 header type one
        BTH_OFF_HDR_TYPE:  rdata_d = {24'h00_0000, BTH_HDR_TYPE_VAL};
        // R3 self test zero
        BTH_OFF_SELF_TEST: rdata_d = {24'h00_0000, BTH_SELF_TEST_VAL};
        // R4 base windows zero
        BTH_OFF_BASE_WIN0: rdata_d = BTH_BASE_WIN_VAL;
        BTH_OFF_BASE_WIN1: rdata_d = BTH_BASE_WIN_VAL;
        BTH_OFF_UP_BUS:    rdata_d = {24'h00_0000, up_bus_q};
        BTH_OFF_DOWN_BUS:  rdata_d = {24'h00_0000, down_bus_q};
        BTH_OFF_HIGH_BUS:  rdata_d = {24'h00_0000, high_bus_q};
        // R8 secondary latency zero
        BTH_OFF_SEC_LAT:   rdata_d = {24'h00_0000, BTH_SEC_LAT_VAL};
        // R14 reserved bits read zero
        BTH_OFF_IO_LOWER:  rdata_d = {24'h00_0000, io_base_q, 3'b000, io_cap};
        default:           rdata_d = BTH_UNMAPPED_VAL;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= BTH_UNMAPPED_VAL;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd(logic [7:0] off);
    reg_rd && (reg_addr == off);
  endsequence

  sequence s_wr(logic [7:0] off);
    reg_wr && (reg_addr == off);
  endsequence

  // R1 reads zero
  AST_PRI_LAT_ZERO: assert property (s_rd(BTH_OFF_PRI_LAT) |=> reg_rdata == 32'h0000_0000) // R1
    else $error("primary latency timer not zero");

  // R2 reads one
  AST_HDR_TYPE_ONE: assert property (s_rd(BTH_OFF_HDR_TYPE) |=> reg_rdata == 32'h0000_0001) // R2
    else $error("header type not one");

  // R3 reads zero
  AST_SELF_TEST_ZERO: assert property ( // R3
    s_rd(BTH_OFF_SELF_TEST) |=> reg_rdata == 32'h0000_0000)
    else $error("self test register not zero");

  // R4 both windows zero
  AST_BASE_WIN_ZERO: assert property ( // R4
    (s_rd(BTH_OFF_BASE_WIN0) or s_rd(BTH_OFF_BASE_WIN1)) |=> reg_rdata == 32'h0000_0000)
    else $error("base window register not zero");

  // R5 write then read back
  AST_UP_BUS_RW: assert property ( // R5
    s_wr(BTH_OFF_UP_BUS) ##1 s_rd(BTH_OFF_UP_BUS)
    |=> reg_rdata == {24'h00_0000, $past(reg_wdata[7:0], 2)})
    else $error("upstream bus number lost a write");

  // R6 write reaches output
  AST_DOWN_BUS_RW: assert property ( // R6
    s_wr(BTH_OFF_DOWN_BUS) |=> downstream_bus_number == $past(reg_wdata[7:0]))
    else $error("downstream bus number not stored");

  // R6 held without a write
  AST_DOWN_BUS_HOLD: assert property ( // R6
    !(reg_wr && (reg_addr == BTH_OFF_DOWN_BUS)) |=> $stable(downstream_bus_number))
    else $error("downstream bus number changed without a write");

  // R7 held until next write
  AST_HIGH_BUS_HOLD: assert property ( // R7
    !(reg_wr && (reg_addr == BTH_OFF_HIGH_BUS)) |=> $stable(highest_bus_behind))
    else $error("highest bus number changed without a write");

  // R8 reads zero
  AST_SEC_LAT_ZERO: assert property (s_rd(BTH_OFF_SEC_LAT) |=> reg_rdata == 32'h0000_0000) // R8
    else $error("secondary latency timer not zero");

  // R9 locked write ignored
  AST_CAP_LOCKED: assert property ( // R9
    (s_wr(BTH_OFF_IO_LOWER) ##0 cap_lock) |=> $stable(io_cap))
    else $error("width bit changed while locked");

  // R9 open write lands
  AST_CAP_OPEN: assert property ( // R9
    (s_wr(BTH_OFF_IO_LOWER) ##0 !cap_lock) |=> io_cap == $past(reg_wdata[0]))
    else $error("width bit ignored an open write");

  // R10 base field stored
  AST_IO_BASE_WR: assert property ( // R10
    s_wr(BTH_OFF_IO_LOWER) |=> io_base_field == $past(reg_wdata[7:4]))
    else $error("io base field not stored");

  // R10 base held without a write
  AST_IO_BASE_HOLD: assert property ( // R10
    !(reg_wr && (reg_addr == BTH_OFF_IO_LOWER)) |=> $stable(io_base_field))
    else $error("io base field changed without a write");

  // R11 request inside window forwards
  AST_IO_FWD_IN: assert property ( // R11
    io_req_valid && (io_cap == BTH_SIXTEEN_BIT_IO)
    && (io_req_addr[AW-1:16] == '0)
    && (io_req_addr[15:12] >= io_base_field)
    && (io_req_addr[15:12] <= io_limit_field)
    |=> io_fwd_valid && io_fwd_hit)
    else $error("in-window request not forwarded");

  // R11 narrow mode drops high addresses
  AST_IO_HIGH_MISS: assert property ( // R11
    io_req_valid && (io_cap == BTH_SIXTEEN_BIT_IO) && (io_req_addr[AW-1:16] != '0)
    |=> io_fwd_valid && !io_fwd_hit)
    else $error("high address forwarded in sixteen-bit mode");

  // R11 one answer per request
  AST_FWD_VALID: assert property (io_req_valid |=> io_fwd_valid) // R11
    else $error("request got no forwarding answer");

  // R11 quiet without request
  AST_FWD_IDLE: assert property (!io_req_valid |=> !io_fwd_valid && !io_fwd_hit) // R11
    else $error("forwarding answer without a request");

  // R12 top page fully inside
  AST_IO_TOP_PAGE: assert property ( // R12
    io_req_valid && (io_cap == BTH_SIXTEEN_BIT_IO)
    && (io_req_addr[AW-1:16] == '0) && (io_req_addr[15:12] == io_limit_field)
    && (io_base_field <= io_limit_field)
    |=> io_fwd_hit)
    else $error("last page of io window not forwarded");

  // R13 mirror follows the base bit
  AST_CAP_MIRROR: assert property (s_rd(BTH_OFF_IO_LOWER) |=> reg_rdata[0] == io_cap_mirror) // R13
    else $error("limit copy of width bit differs");

  // R14 reserved bits read zero
  AST_IO_RSV_ZERO: assert property (s_rd(BTH_OFF_IO_LOWER) |=> reg_rdata[3:1] == 3'b000) // R14
    else $error("reserved io base bits not zero");

  // read data vanish after their one cycle
  AST_RDATA_ONE_CYCLE: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data stood longer than one cycle");

endmodule // bth_cfg_regs

`default_nettype wire

// [logic/bth_pkg.sv]
// constants shared by the bridge header register slice
//
// What this block does
// R1: primary latency timer is an 8-bit read-only register that always reads zero.
// R2: header type register reads a fixed one: type 1, single-function bridge layout.
// R3: self-test register is 8-bit read-only zero; no self-test capability exists.
// R4: both 32-bit base address registers are read-only and always read zero.
// R5: upstream bus number is 8-bit read/write, resets zero, drives no internal behaviour.
// R6: downstream bus number is 8-bit read/write, resets zero, names the secondary bus.
// R7: highest bus behind is 8-bit read/write, resets zero, holds the top bus number.
// R8: secondary latency timer is an 8-bit read-only register that always reads zero.
// R9: I/O base bit 0 gives I/O width, one is 32-bit; resets one, lockable write.
// R10: I/O base bits 7:4 hold address bits 15:12 of window base; reset 0xF.
// R11: I/O base with I/O limit decides whether I/O transactions are forwarded.
// R12: window top is limit bits 15:12 with low twelve address bits all ones.
// R13: limit register capability bit is a read-only mirror of the base capability bit.
// R14: I/O base bits 3:1 read zero and ignore writes.
`default_nettype none

package bth_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses on the configuration port)
  // ---------------------------------------------------------------
  localparam logic [7:0] BTH_OFF_PRI_LAT    = 8'h0d;
  localparam logic [7:0] BTH_OFF_HDR_TYPE   = 8'h0e;
  localparam logic [7:0] BTH_OFF_SELF_TEST  = 8'h0f;
  localparam logic [7:0] BTH_OFF_BASE_WIN0  = 8'h10;
  localparam logic [7:0] BTH_OFF_BASE_WIN1  = 8'h14;
  localparam logic [7:0] BTH_OFF_UP_BUS     = 8'h18;
  localparam logic [7:0] BTH_OFF_DOWN_BUS   = 8'h19;
  localparam logic [7:0] BTH_OFF_HIGH_BUS   = 8'h1a;
  localparam logic [7:0] BTH_OFF_SEC_LAT    = 8'h1b;
  localparam logic [7:0] BTH_OFF_IO_LOWER   = 8'h1c;

  // ---------------------------------------------------------------
  // fixed and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  BTH_PRI_LAT_VAL    = 8'h00;
  localparam logic [7:0]  BTH_HDR_TYPE_VAL   = 8'h01;
  localparam logic [7:0]  BTH_SELF_TEST_VAL  = 8'h00;
  localparam logic [31:0] BTH_BASE_WIN_VAL   = 32'h0000_0000;
  localparam logic [7:0]  BTH_SEC_LAT_VAL    = 8'h00;
  localparam logic [7:0]  BTH_BUS_RST        = 8'h00;
  localparam logic        BTH_IO_CAP_RST     = 1'b1;
  localparam logic [3:0]  BTH_IO_BASE_RST    = 4'hf;
  localparam logic [31:0] BTH_UNMAPPED_VAL   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // io_window_lower field layout
  // ---------------------------------------------------------------
  localparam int BTH_IO_CAP_BIT   = 0;
  localparam int BTH_IO_RSV_LSB   = 1;
  localparam int BTH_IO_RSV_MSB   = 3;
  localparam int BTH_IO_BASE_LSB  = 4;
  localparam int BTH_IO_BASE_MSB  = 7;

  // capability encodings
  localparam logic BTH_SIXTEEN_BIT_IO    = 1'b0;
  localparam logic BTH_THIRTYTWO_BIT_IO  = 1'b1;

  // low address bits below the 4KB window granule
  localparam logic [11:0] BTH_IO_LOW_ZERO = 12'h000;
  localparam logic [11:0] BTH_IO_LOW_ONES = 12'hfff;

endpackage : bth_pkg

`default_nettype wire

// [logic/bth_lock_bit.sv]
// one lockable writable configuration bit
`default_nettype none

module bth_lock_bit
  import bth_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic wr_en,
  input  wire logic lock,
  input  wire logic wdata,
  output var  logic q
);

  logic bit_d;
  logic bit_q;

  // writes land only while the lock is open; a locked write is dropped silently
  always_comb begin
    bit_d = bit_q;
    if (wr_en && !lock) begin
      bit_d = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bit_q <= RST_VAL;
    end else begin
      bit_q <= bit_d;
    end
  end

  assign q = bit_q;

endmodule // bth_lock_bit

`default_nettype wire

// [logic/bth_io_decode.sv]
// I/O window decode that decides forwarding across the bridge
`default_nettype none

module bth_io_decode
  import bth_pkg::*;
#(
  parameter int AW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          io_cap,
  input  wire logic [3:0]    io_base_field,
  input  wire logic [3:0]    io_limit_field,
  input  wire logic [15:0]   io_base_upper,
  input  wire logic [15:0]   io_limit_upper,
  input  wire logic          io_req_valid,
  input  wire logic [AW-1:0] io_req_addr,
  output var  logic          io_fwd_valid,
  output var  logic          io_fwd_hit
);

  logic [31:0] win_lo;
  logic [31:0] win_hi;
  logic [31:0] req_addr;
  logic        hit;
  logic        valid_d;
  logic        valid_q;
  logic        hit_d;
  logic        hit_q;

  // R12 top end fills low bits with ones
  // in 16-bit mode the upper halves are forced to zero, so a high address never matches
  always_comb begin
    req_addr = 32'(io_req_addr);
    if (io_cap == BTH_THIRTYTWO_BIT_IO) begin
      win_lo = {io_base_upper, io_base_field, BTH_IO_LOW_ZERO};
      win_hi = {io_limit_upper, io_limit_field, BTH_IO_LOW_ONES};
    end else begin
      win_lo = {16'h0000, io_base_field, BTH_IO_LOW_ZERO};
      win_hi = {16'h0000, io_limit_field, BTH_IO_LOW_ONES};
    end
    // R11 base and limit gate forwarding
    hit = (req_addr >= win_lo) && (req_addr <= win_hi);
  end

  // result is registered one cycle after the request
  always_comb begin
    valid_d = io_req_valid;
    hit_d   = io_req_valid && hit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      valid_q <= 1'b0;
      hit_q   <= 1'b0;
    end else begin
      valid_q <= valid_d;
      hit_q   <= hit_d;
    end
  end

  assign io_fwd_valid = valid_q;
  assign io_fwd_hit   = hit_q;

endmodule // bth_io_decode

`default_nettype wire

// [sim/bth_host_model.sv]
// host side model: configuration master on the register port
`default_nettype none

module bth_host_model (
  input  wire logic        clk,
  output var  logic [7:0]  reg_addr,
  output var  logic [31:0] reg_wdata,
  output var  logic        reg_wr,
  output var  logic        reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero; called by the bench so one process drives every pin
  task automatic init();
    reg_addr  <= 8'h00;
    reg_wdata <= 32'h0000_0000;
    reg_wr    <= 1'h0;
    reg_rd    <= 1'h0;
  endtask

  // one-cycle write; strobe stays up so a following access can reuse the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    reg_rd    <= 1'h0;
    @(posedge clk);
  endtask

  // one-cycle read; data is due in the following cycle only
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_wr   <= 1'h0;
    reg_rd   <= 1'h1;
    @(posedge clk);
  endtask

  // release strobes; write data toggles so stale data is never trusted
  task automatic idle();
    reg_wr    <= 1'h0;
    reg_rd    <= 1'h0;
    reg_wdata <= ~reg_wdata;
    @(posedge clk);
  endtask
endmodule // bth_host_model

`default_nettype wire

// [sim/bridge_type1_header_bus_io_regs_tb_top.sv]
// self-checking bench for the bridge header register slice
`default_nettype none

module bridge_type1_header_bus_io_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, reg_wr, reg_rd, cap_lock, io_req_valid;
  logic        io_fwd_valid, io_fwd_hit, io_cap_mirror, rd_seen;
  logic [7:0]  reg_addr, downstream_bus_number, highest_bus_behind;
  logic [31:0] reg_wdata, reg_rdata, io_req_addr, w, a, lo, hi;
  logic [3:0]  io_limit_field, io_base_field, lim;
  logic [15:0] io_base_upper, io_limit_upper, bu, lu;
  logic [31:0] rd_q[$];
  logic        hit_q[$];
  logic [31:0] ev[11];
  int          fail_count, total_checks;
  // offsets in order; the last one is unmapped
  logic [7:0]  offs[11] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h14, 8'h18, 8'h19,
                            8'h1a, 8'h1b, 8'h1c, 8'h20};
  logic [31:0] rstv[11] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                            32'h0, 32'h0, 32'hf1, 32'h0};

  bth_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                       .reg_wr(reg_wr), .reg_rd(reg_rd));

  bth_cfg_regs #(.AW(32)) DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cap_lock(cap_lock),
    .io_limit_field(io_limit_field), .io_base_upper(io_base_upper),
    .io_limit_upper(io_limit_upper), .io_req_valid(io_req_valid),
    .io_req_addr(io_req_addr), .io_fwd_valid(io_fwd_valid), .io_fwd_hit(io_fwd_hit),
    .io_cap_mirror(io_cap_mirror), .io_base_field(io_base_field),
    .downstream_bus_number(downstream_bus_number),
    .highest_bus_behind(highest_bus_behind));

  // ----------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read data against the note taken when the read was issued
  task automatic chk_rdata(input logic [31:0] got, input logic [31:0] exp);
    chk_val(got, exp);
  endtask

  // forwarding decision against the window worked out by the bench
  task automatic chk_hit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic rd_exp(input logic [7:0] ad, input logic [31:0] e);
    rd_q.push_back(e);
    host.rd(ad);
  endtask

  // back-to-back reads of every offset against the expectation table
  task automatic read_all();
    for (int i = 0; i < 11; i++) rd_exp(offs[i], ev[i]);
    host.idle();
    host.idle();
  endtask

  // clock at 100 MHz
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // monitor: a result due this cycle takes the oldest note
  always @(posedge clk) begin
    rd_seen <= reg_rd;
    if (rd_seen === 1'h1) chk_rdata(reg_rdata, rd_q.pop_front());
    if (io_fwd_valid === 1'h1) chk_hit(io_fwd_hit, hit_q.pop_front());
  end

  // watchdog against a hung run
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    results();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    host.init();
    rst = 1'h1;
    cap_lock = 1'h0;
    io_req_valid = 1'h0;
    io_req_addr = 32'h0000_0000;
    io_limit_field = 4'h0;
    io_base_upper = 16'h0000;
    io_limit_upper = 16'h0000;
    void'($urandom(32'hf5f1953e));
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    // reset levels at the ports
    chk_val({28'h0, io_base_field}, 32'hf);
    chk_val({31'h0, io_cap_mirror}, 32'h1);
    chk_val({24'h0, highest_bus_behind}, 32'h0);
    ev = rstv;
    read_all();
    // random writes everywhere: read-only places must not move
    for (int n = 0; n < 3; n++) begin
      for (int i = 0; i < 11; i++) begin
        w = $urandom;
        host.wr(offs[i], w);
        if (i >= 5 && i <= 7) ev[i] = {24'h0, w[7:0]};
        else if (i == 9) ev[i] = {24'h0, w[7:4], 3'h0, w[0]};
      end
      read_all();
      chk_val({24'h0, downstream_bus_number}, ev[6]);
      chk_val({24'h0, highest_bus_behind}, ev[7]);
      chk_val({28'h0, io_base_field}, {28'h0, ev[9][7:4]});
    end
    // write then read straight back with no gap
    w = $urandom;
    host.wr(8'h18, w);
    ev[5] = {24'h0, w[7:0]};
    rd_exp(8'h18, ev[5]);
    host.idle();
    // locked width bit ignores the write, base field still moves
    cap_lock <= 1'h1;
    host.wr(8'h1c, {24'h0, 4'h5, 3'h7, ~ev[9][0]});
    ev[9] = {24'h0, 4'h5, 3'h0, ev[9][0]};
    read_all();
    cap_lock <= 1'h0;
    // second reset in mid-run restores defaults
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    ev = rstv;
    read_all();
    // forwarding decode in both address widths, boundaries first
    for (int m = 0; m < 2; m++) begin
      w = $urandom;
      bu = 16'($urandom_range(0, 3));
      lu = bu + 16'($urandom_range(0, 1));
      lim = 4'($urandom);
      io_base_upper <= bu;
      io_limit_upper <= lu;
      io_limit_field <= lim;
      host.wr(8'h1c, {24'h0, w[7:4], 3'h0, m[0]});
      host.idle();
      chk_val({31'h0, io_cap_mirror}, {31'h0, m[0]});
      lo = {(m == 1) ? bu : 16'h0000, w[7:4], 12'h000};
      hi = {(m == 1) ? lu : 16'h0000, lim, 12'hfff};
      for (int k = 0; k < 40; k++) begin
        a = {16'($urandom_range(0, 3)), 16'($urandom)};
        case (k)
          0: a = lo;
          1: a = hi;
          2: a = hi + 32'h1;
          3: a = lo - 32'h1;
          default: ;
        endcase
        io_req_valid <= 1'h1;
        io_req_addr <= a;
        hit_q.push_back(a >= lo && a <= hi);
        @(posedge clk);
      end
      io_req_valid <= 1'h0;
      repeat (3) @(posedge clk);
    end
    chk_val(32'(rd_q.size() + hit_q.size()), 32'h0);
    results();
  end
endmodule // bridge_type1_header_bus_io_regs_tb_top

`default_nettype wire
